// ### design/mspi_pkg.sv
/*
 * Package for the master-only SPI mode serial port: register map,
 * field positions, reset values, state and carrier types.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package mspi_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] data_off = 12'h000;
    localparam logic [11:0] status_off = 12'h004;
    localparam logic [11:0] control_off = 12'h008;
    localparam logic [11:0] format_off = 12'h00c;
    localparam logic [11:0] baud_off = 12'h010;
    localparam logic [11:0] cpu_status_off = 12'h014;
    localparam logic [11:0] irq_ack_off = 12'h018;

    // ==========================================================
    // Status bit positions
    localparam int rxc_bit = 7;
    localparam int txc_bit = 6;
    localparam int udre_bit = 5;

    // Control bit positions
    localparam int rxcie_bit = 7;
    localparam int txcie_bit = 6;
    localparam int tx_empty_irq_enable_bit = 5;
    localparam int rxen_bit = 4;
    localparam int txen_bit = 3;

    // Format bit positions
    localparam int mode_hi_bit = 7;
    localparam int mode_lo_bit = 6;
    localparam int order_bit = 2;
    localparam int phase_bit = 1;
    localparam int polarity_bit = 0;

    // Global interrupt bit in the cpu status register
    localparam int global_irq_bit = 7;

    // ==========================================================
    // Reset values
    localparam logic [7:0] control_rst = 8'h06;
    localparam logic [7:0] format_rst = 8'h06;
    localparam logic [15:0] baud_rst = 16'h0000;

    // Mode select encodings
    localparam logic [1:0] mode_async = 2'h0;
    localparam logic [1:0] mode_sync = 2'h1;
    localparam logic [1:0] mode_master_spi = 2'h3;

    // Bits in one frame and receive buffer depth
    localparam int frame_bits = 8;
    localparam logic [2:0] last_bit_idx = 3'h7;
    localparam int rx_depth = 2;

    // ==========================================================
    // Shifter states
    typedef enum logic [1:0] {
        st_idle,
        st_lead,
        st_trail
    } shift_state_t;

    // Interrupt request group
    typedef struct packed {
        logic rx_complete;
        logic tx_complete;
        logic tx_empty;
    } irq_req_t;

    // Serial pin group
    typedef struct packed {
        logic serial_clock_pin;
        logic serial_out_pin;
        logic serial_out_override;
        logic serial_in_override;
    } serial_pins_t;

endpackage

// ### design/usart_master_spi_mode.sv
/*
 * Master-only SPI mode serial port with an APB register slave.
 * Holds the data path (double-buffered transmit, two-level receive),
 * the baud divider, flags and the interrupt request terms.
 * Assumes the serial input is synchronous to pclk and that the
 * cpu core acknowledges a taken transmit-complete interrupt by a
 * one-cycle pulse on tx_irq_taken.
 */
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - Error flags unused, always read zero
// - Receive flag shows unread data, flushed off
// - Transmit done after frame, buffer empty
// - Transmit flag cleared by service or one
// - Buffer-empty flag high when writable, reset set
// - Receive irq needs enable, global, flag
// - Transmit irq needs enable, global, flag
// - Empty irq needs enable, global, flag
// - Receiver enable takes input, clear flushes
// - Transmitter enable takes the output pin
// - Transmitter stays until shift and buffer empty
// - Mode field must select master spi; other values stop transfers
// - Order, phase, polarity taken with mode write
// - Order bit selects lsb or msb first
// - Phase selects leading or trailing sampling
// - Polarity sets clock idle level
// - Double transmit buffer, extra receive level
// - No double speed bit; divider only
// - Master only, no slave select input
// - Data write starts transfer when shifter free
// - Eight-bit frames, line idles high
// - Overflow drops newest byte, keeps older
// - Polarity and phase give modes 0-3
module usart_master_spi_mode (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_in_pin,
    input wire logic tx_irq_taken,
    output mspi_pkg::serial_pins_t pins,
    output mspi_pkg::irq_req_t irq
);

    // ==========================================================
    // Register state
    logic [7:0] control_r;
    logic [7:0] format_r;
    logic [15:0] baud_r;
    logic global_irq_r;
    logic [7:0] tx_buf_r;
    logic tx_buf_full_r;
    logic [7:0] tx_shift_r;
    logic [7:0] rx_shift_r;
    logic [7:0] rx_mem_r [mspi_pkg::rx_depth];
    logic [1:0] rx_count_r;
    logic rx_rd_ptr_r;
    logic rx_wr_ptr_r;
    logic txc_r;
    logic [2:0] bit_idx_r;
    logic [15:0] baud_cnt_r;
    logic sck_r;
    logic out_bit_r;
    logic tx_active_r;
    mspi_pkg::shift_state_t state_r;

    logic wr_en;
    logic rd_en;
    logic data_wr;
    logic data_rd;
    logic status_wr;
    logic tick;
    logic start_frame;
    logic frame_done;
    logic sample_now;
    logic rx_push;
    logic rx_pop;
    logic spi_mode;
    logic rxen;
    logic txen;
    logic order_lsb;
    logic cpha;
    logic cpol;
    logic in_bit;
    logic [7:0] rx_next;

    // ==========================================================
    // Bus decode: zero wait states, no error
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign data_wr = wr_en & (paddr == mspi_pkg::data_off) & pstrb[0];
    assign data_rd = rd_en & (paddr == mspi_pkg::data_off);
    assign status_wr = wr_en & (paddr == mspi_pkg::status_off) & pstrb[0];

    // Control and format field views
    assign spi_mode = (format_r[mspi_pkg::mode_hi_bit:mspi_pkg::mode_lo_bit]
                       == mspi_pkg::mode_master_spi);
    assign rxen = control_r[mspi_pkg::rxen_bit];
    assign txen = control_r[mspi_pkg::txen_bit];
    assign order_lsb = format_r[mspi_pkg::order_bit];
    assign cpha = format_r[mspi_pkg::phase_bit];
    assign cpol = format_r[mspi_pkg::polarity_bit];

    // Control register; reserved low bits keep their fixed values
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            control_r <= mspi_pkg::control_rst;
        else if (wr_en && paddr == mspi_pkg::control_off && pstrb[0])
            control_r <= {pwdata[7:3], mspi_pkg::control_rst[2:0]};
    end

    // Format register: mode, order, phase, polarity in one write
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            format_r <= mspi_pkg::format_rst;
        else if (wr_en && paddr == mspi_pkg::format_off && pstrb[0])
            format_r <= {pwdata[7:6], 3'h0, pwdata[2:0]};
    end

    // Baud divider, the only way to speed up the clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            baud_r <= mspi_pkg::baud_rst;
        else if (wr_en && paddr == mspi_pkg::baud_off)
        begin
            if (pstrb[0])
                baud_r[7:0] <= pwdata[7:0];
            if (pstrb[1])
                baud_r[15:8] <= pwdata[15:8];
        end
    end

    // Global interrupt flag mirrored from the cpu status register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            global_irq_r <= 1'b0;
        else if (wr_en && paddr == mspi_pkg::cpu_status_off && pstrb[0])
            global_irq_r <= pwdata[mspi_pkg::global_irq_bit];
    end

    // ==========================================================
    // Transmit buffer; the second level of the double buffer
    assign start_frame = (state_r == mspi_pkg::st_idle) & tx_buf_full_r
                         & txen & spi_mode;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_buf_r <= 8'h00;
            tx_buf_full_r <= 1'b0;
        end
        else if (data_wr && !tx_buf_full_r && txen)
        begin
            tx_buf_r <= pwdata[7:0];
            tx_buf_full_r <= 1'b1;
        end
        else if (start_frame)
            tx_buf_full_r <= 1'b0;
    end

    // Baud tick: one per half serial period, baud_r + 1 cycles
    assign tick = (baud_cnt_r == 16'h0000);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            baud_cnt_r <= 16'h0000;
        else if (state_r == mspi_pkg::st_idle || tick)
            baud_cnt_r <= baud_r;
        else
            baud_cnt_r <= baud_cnt_r - 16'h0001;
    end

    // Bit sampled on the leading edge when phase is 0, else trailing
    assign sample_now = tick &
        (((state_r == mspi_pkg::st_lead) & ~cpha) |
         ((state_r == mspi_pkg::st_trail) & cpha));
    assign frame_done = tick & (state_r == mspi_pkg::st_trail)
                        & (bit_idx_r == mspi_pkg::last_bit_idx);
    assign in_bit = rxen ? serial_in_pin : 1'b0;

    // Receive shifter with this edge's bit merged in; with trailing-edge
    // sampling the eighth bit arrives on the very edge that stores the
    // byte, so the store must read this merged value, not the register
    always_comb
    begin
        rx_next = rx_shift_r;
        if (sample_now)
        begin
            if (order_lsb)
                rx_next[bit_idx_r] = in_bit;
            else
                rx_next[3'h7 - bit_idx_r] = in_bit;
        end
    end

    // Shifter: lead half then trail half per bit, eight bits a frame
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= mspi_pkg::st_idle;
            bit_idx_r <= 3'h0;
            tx_shift_r <= 8'h00;
            rx_shift_r <= 8'h00;
            sck_r <= 1'b0;
            out_bit_r <= 1'b1;
        end
        else
        begin
            case (state_r)
                mspi_pkg::st_idle:
                begin
                    sck_r <= cpol;
                    bit_idx_r <= 3'h0;
                    if (start_frame)
                    begin
                        state_r <= mspi_pkg::st_lead;
                        tx_shift_r <= tx_buf_r;
                        // First bit set up before the leading edge
                        out_bit_r <= order_lsb ? tx_buf_r[0]
                                     : tx_buf_r[7];
                    end
                    else
                        out_bit_r <= 1'b1;
                end
                mspi_pkg::st_lead:
                    if (tick)
                    begin
                        sck_r <= ~cpol; // leading edge
                        state_r <= mspi_pkg::st_trail;
                        if (cpha)
                            out_bit_r <= order_lsb ? tx_shift_r[bit_idx_r]
                                         : tx_shift_r[3'h7 - bit_idx_r];
                    end
                mspi_pkg::st_trail:
                    if (tick)
                    begin
                        sck_r <= cpol; // trailing edge
                        bit_idx_r <= bit_idx_r + 3'h1;
                        if (frame_done)
                            state_r <= mspi_pkg::st_idle;
                        else
                        begin
                            state_r <= mspi_pkg::st_lead;
                            if (!cpha)
                                out_bit_r <= order_lsb
                                    ? tx_shift_r[bit_idx_r + 3'h1]
                                    : tx_shift_r[3'h6 - bit_idx_r];
                        end
                    end
                default:
                    state_r <= mspi_pkg::st_idle;
            endcase
            // Received bit already sits in its final position
            rx_shift_r <= rx_next;
        end
    end

    // ==========================================================
    // Receive buffer: two entries; a full buffer drops the newcomer
    assign rx_pop = data_rd & (rx_count_r != 2'h0);
    assign rx_push = frame_done & rxen &
                     ((rx_count_r != 2'h2) | rx_pop);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_count_r <= 2'h0;
            rx_rd_ptr_r <= 1'b0;
            rx_wr_ptr_r <= 1'b0;
            rx_mem_r[0] <= 8'h00;
            rx_mem_r[1] <= 8'h00;
        end
        else if (!rxen)
        begin
            // Disabling the receiver flushes everything held
            rx_count_r <= 2'h0;
            rx_rd_ptr_r <= 1'b0;
            rx_wr_ptr_r <= 1'b0;
        end
        else
        begin
            if (rx_push)
            begin
                rx_mem_r[rx_wr_ptr_r] <= rx_next;
                rx_wr_ptr_r <= ~rx_wr_ptr_r;
            end
            if (rx_pop)
                rx_rd_ptr_r <= ~rx_rd_ptr_r;
            if (rx_push && !rx_pop)
                rx_count_r <= rx_count_r + 2'h1;
            else if (rx_pop && !rx_push)
                rx_count_r <= rx_count_r - 2'h1;
        end
    end

    // Transmit complete: set wins over clear in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            txc_r <= 1'b0;
        else if (frame_done && !tx_buf_full_r)
            txc_r <= 1'b1;
        else if (tx_irq_taken ||
                 (status_wr && pwdata[mspi_pkg::txc_bit]))
            txc_r <= 1'b0;
    end

    // Transmit pin stays claimed until shifter and buffer drain
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_active_r <= 1'b0;
        else if (txen)
            tx_active_r <= 1'b1;
        else if (state_r == mspi_pkg::st_idle && !tx_buf_full_r)
            tx_active_r <= 1'b0;
    end

    // ==========================================================
    // Pins and interrupt requests; master only, no select input
    assign pins.serial_clock_pin = sck_r;
    assign pins.serial_out_pin = out_bit_r;
    assign pins.serial_out_override = tx_active_r;
    assign pins.serial_in_override = rxen;
    assign irq.rx_complete = control_r[mspi_pkg::rxcie_bit] & global_irq_r
                             & (rx_count_r != 2'h0);
    assign irq.tx_complete = control_r[mspi_pkg::txcie_bit] & global_irq_r
                             & txc_r;
    assign irq.tx_empty = control_r[mspi_pkg::tx_empty_irq_enable_bit] & global_irq_r
                          & ~tx_buf_full_r;

    // Read data from flops; error flags bits 4:0 always zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (psel && !penable && !pwrite)
        begin
            if (paddr == mspi_pkg::data_off)
                prdata <= {24'h000000, rx_mem_r[rx_rd_ptr_r]};
            else if (paddr == mspi_pkg::status_off)
                prdata <= {24'h000000, (rx_count_r != 2'h0), txc_r,
                           ~tx_buf_full_r, 5'h00};
            else if (paddr == mspi_pkg::control_off)
                prdata <= {24'h000000, control_r};
            else if (paddr == mspi_pkg::format_off)
                prdata <= {24'h000000, format_r};
            else if (paddr == mspi_pkg::baud_off)
                prdata <= {16'h0000, baud_r};
            else if (paddr == mspi_pkg::cpu_status_off)
                prdata <= {24'h000000, global_irq_r, 7'h00};
            else
                prdata <= 32'h0000_0000;
        end
    end

endmodule
`default_nettype wire

// ### tb/mspi_asserts.sv
/* Checker for the master SPI port: irq terms, pin ownership, reads.
   Bound to the top module below; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module mspi_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic tx_irq_taken,
    input wire mspi_pkg::serial_pins_t pins,
    input wire mspi_pkg::irq_req_t irq
);
    logic wr;
    logic [7:0] ctl_r;
    logic [7:0] fmt_r;
    logic glb_r;

    // ==========================================================
    // Shadow of written enables; irq terms are judged against it
    assign wr = psel && penable && pwrite;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_r <= 8'h06;
            fmt_r <= 8'h06;
            glb_r <= 1'b0;
        end
        else if (wr)
        begin
            if (paddr == mspi_pkg::control_off)
                ctl_r <= pwdata[7:0];
            if (paddr == mspi_pkg::format_off)
                fmt_r <= pwdata[7:0];
            if (paddr == mspi_pkg::cpu_status_off)
                glb_r <= pwdata[7];
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ==========================================================
    // Assertions
    AST_STATUS_LOW: assert property (
        psel && !penable && !pwrite && paddr == mspi_pkg::status_off
        |=> prdata[4:0] == 5'h00)
        else $error("status error bits not zero");
    AST_RX_IRQ: assert property (
        irq.rx_complete |-> ctl_r[7] && glb_r)
        else $error("receive irq without enables");
    AST_TX_IRQ: assert property (
        irq.tx_complete |-> ctl_r[6] && glb_r)
        else $error("transmit irq without enables");
    AST_EMPTY_IRQ: assert property (
        irq.tx_empty |-> ctl_r[5] && glb_r)
        else $error("empty irq without enables");
    AST_TX_CLEAR: assert property (
        tx_irq_taken || wr && paddr == mspi_pkg::status_off && pwdata[6]
        |=> !irq.tx_complete)
        else $error("transmit flag not cleared");
    AST_RX_PIN: assert property (
        pins.serial_in_override == ctl_r[4])
        else $error("input pin ownership differs from enable");
    AST_TX_PIN_ON: assert property (
        $rose(ctl_r[3]) |-> ##[0:1] pins.serial_out_override)
        else $error("output pin not taken");
    AST_TX_PIN_OFF: assert property (
        $fell(pins.serial_out_override) |-> !ctl_r[3])
        else $error("output pin released while enabled");
    AST_SCK_IDLE: assert property (
        $changed(pins.serial_clock_pin) |-> pins.serial_out_override
        || $past(pins.serial_out_override)
        || fmt_r[0] != $past(fmt_r[0], 2))
        else $error("serial clock moved outside a frame");

    // Main scenarios reached
    cover property (irq.rx_complete && irq.tx_complete);
    cover property ($fell(pins.serial_out_override));
    cover property (tx_irq_taken);
endmodule

bind usart_master_spi_mode mspi_asserts asserts_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .tx_irq_taken(tx_irq_taken), .pins(pins), .irq(irq));
`default_nettype wire

// ### tb/spi_echo_slave.sv
/* Behavioural SPI slave: sends back each byte one frame later.
   Mode comes from the bench; while arm is high it waits in start state,
   standing in for the slave select this port lacks. */
`timescale 1ns/1ps
`default_nettype none
module spi_echo_slave (
    input wire logic sck,
    input wire logic mosi,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsb,
    input wire logic arm,
    output logic miso,
    output logic [7:0] got,
    output logic done_t
);
    logic [7:0] tx = 8'h3c;
    logic [7:0] rx = 8'h00;
    int ns = 0;
    int nd = 0;

    // ==========================================================
    // Next bit out, in the chosen order
    task automatic drive();
        miso = lsb ? tx[nd] : tx[7 - nd];
        nd++;
    endtask

    // Byte end: report, echo it next, line no longer meaningful
    task automatic finish();
        got = rx;
        done_t = !done_t;
        tx = rx;
        ns = 0;
        nd = 0;
        miso = !miso;
    endtask

    initial
    begin
        miso = 1'b1;
        got = 8'h00;
        done_t = 1'b0;
    end

    // Phase 0 needs its first bit out before the leading edge
    always @(negedge arm)
    begin
        ns = 0;
        nd = 0;
        if (!cpha)
            drive();
    end

    // Leading edge leaves idle level; sample edge set by phase
    always @(sck)
    begin
        if (!arm)
        begin
            if ((sck != cpol) != cpha)
            begin
                rx = lsb ? {mosi, rx[7:1]} : {rx[6:0], mosi};
                ns++;
                if (ns == 8 && cpha)
                    finish();
            end
            else
            begin
                if (ns == 8)
                    finish();
                drive();
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/usart_master_spi_mode_tb.sv
/* Self-checking bench for the master SPI port: APB driver, an echo
   slave, and monitors that meet queued expectations. */
`timescale 1ns/1ps
`default_nettype none
module usart_master_spi_mode_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic tx_irq_taken = 1'b0;
    logic want = 1'b0;
    logic arm = 1'b1;
    logic [2:0] mode = 3'h0;
    logic miso;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] got;
    logic done_t;
    logic [7:0] seed = 8'h16;
    logic [7:0] echo = 8'h3c;
    logic [7:0] b [3];
    logic [31:0] rv;
    logic [31:0] rq [$];
    logic [7:0] tq [$];
    int num_errors = 0;
    int n_tests = 0;
    mspi_pkg::serial_pins_t pins;
    mspi_pkg::irq_req_t irq;

    usart_master_spi_mode dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_in_pin(miso),
        .tx_irq_taken(tx_irq_taken), .pins(pins), .irq(irq));
    spi_echo_slave slave_u (.sck(pins.serial_clock_pin),
        .mosi(pins.serial_out_pin), .cpol(mode[0]), .cpha(mode[1]),
        .lsb(mode[2]), .arm(arm), .miso(miso), .got(got), .done_t(done_t));

    initial
    begin
        forever #5 pclk = ~pclk;
    end

    // ==========================================================
    // Shared tasks
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic print_verdict();
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Leading edge wait keeps strobes from being set twice in a step
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic k);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        want <= k;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do
        begin
            @(posedge pclk);
            i++;
        end
        while (pready !== 1'b1 && i < 50);
        rv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        want <= 1'b0;
        if (pready !== 1'b1)
        begin
            num_errors++;
            print_verdict();
        end
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        rq.push_back(exp);
        apb(1'b0, a, 32'h0, 1'b1);
    endtask

    task automatic waitbit(input int n);
        int i;
        for (i = 0; i < 200; i++)
        begin
            apb(1'b0, mspi_pkg::status_off, 32'h0, 1'b0);
            if (rv[n] === 1'b1)
                break;
        end
        if (i == 200)
        begin
            num_errors++;
            print_verdict();
        end
    endtask

    // ==========================================================
    // Monitors: read data and bytes seen by the slave
    always @(posedge pclk)
        if (psel && penable && !pwrite && want)
            check(prdata, rq.pop_front());
    always @(done_t)
        if ($time > 0)
            check({24'h0, got}, {24'h0, tq.pop_front()});

    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(mspi_pkg::status_off, 32'h20);
        rd(mspi_pkg::control_off, 32'h06);
        apb(1'b1, mspi_pkg::irq_ack_off, 32'hff, 1'b0);
        rd(mspi_pkg::irq_ack_off, 32'h0);
        apb(1'b1, mspi_pkg::baud_off, 32'h1, 1'b0);
        apb(1'b1, mspi_pkg::format_off, 32'hc0, 1'b0);
        apb(1'b1, mspi_pkg::control_off, 32'h18, 1'b0);
        // Every order, phase and polarity; third byte overflows
        for (int m = 0; m < 8; m++)
        begin
            arm <= 1'b1;
            mode <= m[2:0];
            apb(1'b1, mspi_pkg::format_off, {24'h0, 5'h18, m[2:0]},
                1'b0);
            repeat (2) @(posedge pclk);
            arm <= 1'b0;
            for (int k = 0; k < 3; k++)
            begin
                seed = lfsr(seed);
                b[k] = seed;
                tq.push_back(seed);
                waitbit(mspi_pkg::udre_bit);
                apb(1'b1, mspi_pkg::data_off, {24'h0, seed}, 1'b0);
            end
            waitbit(mspi_pkg::txc_bit);
            rd(mspi_pkg::status_off, 32'he0);
            apb(1'b1, mspi_pkg::status_off, 32'h40, 1'b0);
            rd(mspi_pkg::status_off, 32'ha0);
            rd(mspi_pkg::data_off, {24'h0, echo});
            rd(mspi_pkg::data_off, {24'h0, b[0]});
            rd(mspi_pkg::status_off, 32'h20);
            echo = b[2];
        end
        // Interrupt terms: raise, service, mask
        seed = lfsr(seed);
        tq.push_back(seed);
        apb(1'b1, mspi_pkg::cpu_status_off, 32'h80, 1'b0);
        apb(1'b1, mspi_pkg::data_off, {24'h0, seed}, 1'b0);
        waitbit(mspi_pkg::txc_bit);
        apb(1'b1, mspi_pkg::control_off, 32'hf8, 1'b0);
        @(negedge pclk);
        check({29'h0, irq}, 32'h7);
        @(posedge pclk);
        tx_irq_taken <= 1'b1;
        @(posedge pclk);
        tx_irq_taken <= 1'b0;
        @(negedge pclk);
        check({29'h0, irq}, 32'h5);
        apb(1'b1, mspi_pkg::cpu_status_off, 32'h0, 1'b0);
        @(negedge pclk);
        check({29'h0, irq}, 32'h0);
        rd(mspi_pkg::data_off, {24'h0, echo});
        // Disable mid-frame: frame finishes, receive side is flushed
        seed = lfsr(seed);
        tq.push_back(seed);
        apb(1'b1, mspi_pkg::data_off, {24'h0, seed}, 1'b0);
        apb(1'b1, mspi_pkg::control_off, 32'h00, 1'b0);
        waitbit(mspi_pkg::txc_bit);
        rd(mspi_pkg::status_off, 32'h60);
        @(negedge pclk);
        check({31'h0, pins.serial_out_override}, 32'h0);
        check({24'h0, 7'h0, tq.size() == 0}, 32'h1);
        print_verdict();
    end
endmodule
`default_nettype wire
